/* File: core/rtcab_bkp_if.sv */
// Carrier between the clock core and its backup register store.
`timescale 1ns/10ps
interface rtcab_bkp_if;
    import rtcab_pkg::*;
    logic we;
    logic [BKP_IDX_W-1:0] idx;
    logic [BKP_W-1:0] wdata;
    logic [BKP_W-1:0] rdata;
    modport ctl (output we, output idx, output wdata, input rdata);
    modport store (input we, input idx, input wdata, output rdata);
endinterface

/* File: core/rtcab_bkp_store.sv */
// Ten 16-bit backup registers with a registered read port.
`timescale 1ns/10ps
module rtcab_bkp_store
    import rtcab_pkg::*;
#(
    parameter int N = BKP_N
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    rtcab_bkp_if.store bus
);
    logic [BKP_W-1:0] mem_q [N];
    logic [BKP_W-1:0] mem_d [N];
    logic [BKP_W-1:0] rdata_q;
    logic [BKP_W-1:0] rdata_d;

    // The store only clears on rst_in, which models loss of the backup supply, not standby.
    always_comb begin
        rdata_d = BKP_RST;
        if (int'(bus.idx) < N) begin
            rdata_d = mem_q[bus.idx];
        end
    end

    generate
        for (genvar i = 0; i < N; i++) begin : g_word
            always_comb begin
                mem_d[i] = mem_q[i];
                if (bus.we && int'(bus.idx) == i) begin
                    mem_d[i] = bus.wdata;
                end
            end
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    mem_q[i] <= BKP_RST;
                end else begin
                    mem_q[i] <= mem_d[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_q <= BKP_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus.rdata = rdata_q;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    bkp_readback_a: assert property (
        (bus.we && int'(bus.idx) < N) ##1 (!bus.we && bus.idx == $past(bus.idx))
        |=> bus.rdata == $past(bus.wdata, 2))
        else $error("Backup word did not read back as written.");

endmodule

/* File: core/rtcab_core.sv */
// Real-time clock core: source select, prescaler, counter, alarm, calibration and wake.
`timescale 1ns/10ps
module rtcab_core
    import rtcab_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [1:0] src_sel_in,
    input wire logic slow_xtal_tick_in,
    input wire logic lp_rc_tick_in,
    input wire logic fast_external_osc_tick_in,
    input wire logic [PRESC_W-1:0] presc_reload_in,
    input wire logic presc_reload_we_in,
    input wire logic cnt_load_in,
    input wire logic [CNT_W-1:0] cnt_value_in,
    input wire logic cmp_we_in,
    input wire logic [CNT_W-1:0] cmp_value_in,
    input wire logic alarm_clear_in,
    input wire logic cal_enable_in,
    input wire logic bkp_we_in,
    input wire logic [BKP_IDX_W-1:0] bkp_idx_in,
    input wire logic [BKP_W-1:0] bkp_wdata_in,
    input wire logic standby_in,
    input wire logic external_reset_pin_in,
    input wire logic independent_watchdog_rst_in,
    input wire logic wakeup_pin_in,
    output logic [CNT_W-1:0] count_out,
    output logic tick_irq_out,
    output logic alarm_irq_out,
    output logic alarm_flag_out,
    output logic alarm_event_out,
    output logic standby_exit_out,
    output logic cal_out,
    output logic [BKP_W-1:0] bkp_rdata_out
);
    rtcab_bkp_if bkp ();

    logic [FAST_DIV_W-1:0] fdiv_q;
    logic [FAST_DIV_W-1:0] fdiv_d;
    logic fast_en;
    logic src_en;

    logic [PRESC_W-1:0] reload_q;
    logic [PRESC_W-1:0] reload_d;
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic tick;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cmp_q;
    logic [CNT_W-1:0] cmp_d;
    logic hit;

    logic tick_irq_q;
    logic tick_irq_d;
    logic alarm_irq_q;
    logic alarm_irq_d;
    logic alarm_flag_q;
    logic alarm_flag_d;
    logic alarm_evt_q;
    logic alarm_evt_d;
    logic wake_q;
    logic wake_d;
    logic wakeup_prev_q;

    logic [CAL_W-1:0] cal_cnt_q;
    logic [CAL_W-1:0] cal_cnt_d;
    logic cal_q;
    logic cal_d;

    // The fast oscillator is far too quick for a time base, so it is cut down by 128 first.
    always_comb begin
        fdiv_d = fdiv_q;
        fast_en = 1'b0;
        if (fast_external_osc_tick_in) begin
            fdiv_d = fdiv_q + FAST_DIV_STEP;
            fast_en = (fdiv_q == FAST_DIV_LAST);
        end
    end

    always_comb begin
        case (rtcab_src_t'(src_sel_in))
            RTCAB_SRC_SLOW_XTAL: src_en = slow_xtal_tick_in;
            RTCAB_SRC_LP_RC: src_en = lp_rc_tick_in;
            RTCAB_SRC_FAST_DIV: src_en = fast_en;
            default: src_en = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            fdiv_q <= FAST_DIV_RST;
        end else begin
            fdiv_q <= fdiv_d;
        end
    end

    // The standby input deliberately gates nothing here, so time keeps moving.
    always_comb begin
        reload_d = reload_q;
        presc_d = presc_q;
        tick = 1'b0;
        if (presc_reload_we_in) begin
            reload_d = presc_reload_in;
        end
        if (src_en) begin
            if (presc_q == PRESC_ZERO) begin
                presc_d = reload_q;
                tick = 1'b1;
            end else begin
                presc_d = presc_q - PRESC_STEP;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reload_q <= PRESC_RELOAD_RST;
            presc_q <= PRESC_RELOAD_RST;
        end else begin
            reload_q <= reload_d;
            presc_q <= presc_d;
        end
    end

    // A software load wins over a tick in the same cycle; that tick's step is dropped.
    always_comb begin
        cnt_d = cnt_q;
        cmp_d = cmp_q;
        if (cmp_we_in) begin
            cmp_d = cmp_value_in;
        end
        if (cnt_load_in) begin
            cnt_d = cnt_value_in;
        end else if (tick) begin
            cnt_d = cnt_q + CNT_STEP;
        end
        hit = (cnt_d != cnt_q) && (cnt_d == cmp_d);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cnt_q <= CNT_RST;
            cmp_q <= CMP_RST;
        end else begin
            cnt_q <= cnt_d;
            cmp_q <= cmp_d;
        end
    end

    // The flag is only set when the count moves onto the compare value, so it never re-fires
    // while the two simply stay equal; a new hit in the clear cycle keeps the flag set.
    always_comb begin
        tick_irq_d = tick;
        alarm_irq_d = hit;
        alarm_evt_d = hit;
        alarm_flag_d = alarm_flag_q;
        if (alarm_clear_in) begin
            alarm_flag_d = 1'b0;
        end
        if (hit) begin
            alarm_flag_d = 1'b1;
        end
        wake_d = standby_in && (hit || external_reset_pin_in || independent_watchdog_rst_in
            || (wakeup_pin_in && !wakeup_prev_q));
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            tick_irq_q <= 1'b0;
            alarm_irq_q <= 1'b0;
            alarm_evt_q <= 1'b0;
            alarm_flag_q <= 1'b0;
            wake_q <= 1'b0;
            wakeup_prev_q <= 1'b0;
        end else begin
            tick_irq_q <= tick_irq_d;
            alarm_irq_q <= alarm_irq_d;
            alarm_evt_q <= alarm_evt_d;
            alarm_flag_q <= alarm_flag_d;
            wake_q <= wake_d;
            wakeup_prev_q <= wakeup_pin_in;
        end
    end

    // 32 source edges per half period gives 512 Hz from a 32.768 kHz source.
    always_comb begin
        cal_cnt_d = cal_cnt_q;
        cal_d = cal_q;
        if (!cal_enable_in) begin
            cal_cnt_d = CAL_RST;
            cal_d = 1'b0;
        end else if (src_en) begin
            cal_cnt_d = cal_cnt_q + CAL_STEP;
            if (cal_cnt_q == CAL_HALF_LAST) begin
                cal_d = !cal_q;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cal_cnt_q <= CAL_RST;
            cal_q <= 1'b0;
        end else begin
            cal_cnt_q <= cal_cnt_d;
            cal_q <= cal_d;
        end
    end

    // Only rst_in clears clock and backup state; standby is just an input here.
    assign bkp.we = bkp_we_in;
    assign bkp.idx = bkp_idx_in;
    assign bkp.wdata = bkp_wdata_in;

    rtcab_bkp_store #(
        .N(BKP_N)
    ) u_bkp (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .bus(bkp)
    );

    assign count_out = cnt_q;
    assign tick_irq_out = tick_irq_q;
    assign alarm_irq_out = alarm_irq_q;
    assign alarm_flag_out = alarm_flag_q;
    assign alarm_event_out = alarm_evt_q;
    assign standby_exit_out = wake_q;
    assign cal_out = cal_q;
    assign bkp_rdata_out = bkp.rdata;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    cnt_step_a: assert property (
        tick_irq_out && !$past(cnt_load_in) |-> count_out == $past(count_out) + CNT_STEP)
        else $error("Counter did not step by one on the time-base tick.");

    tick_reload_a: assert property (
        tick_irq_out |-> presc_q == $past(reload_q))
        else $error("Prescaler did not reload at the end of its period.");

    presc_run_a: assert property (
        src_en && presc_q != PRESC_ZERO |=> presc_q == $past(presc_q) - PRESC_STEP)
        else $error("Prescaler failed to count down on a source edge.");

    fast_div_a: assert property (
        fast_en |=> fdiv_q == FAST_DIV_RST)
        else $error("Fast source divider did not wrap after its 128th edge.");

    alarm_match_a: assert property (
        alarm_irq_out |-> count_out == cmp_q && count_out != $past(count_out))
        else $error("Alarm raised without a fresh compare match.");

    alarm_once_a: assert property (
        alarm_irq_out && !cnt_load_in && !cmp_we_in |=> !alarm_irq_out)
        else $error("Alarm requested twice for one match.");

    flag_set_a: assert property (
        hit |=> alarm_flag_out)
        else $error("Alarm flag not set by a compare match.");

    flag_hold_a: assert property (
        alarm_flag_out && !alarm_clear_in |=> alarm_flag_out [*2] or alarm_clear_in)
        else $error("Alarm flag dropped without a clear.");

    alarm_route_a: assert property (
        alarm_irq_out == alarm_event_out)
        else $error("Alarm not mirrored on the external event line.");

    standby_wake_a: assert property (
        standby_in && hit |=> standby_exit_out)
        else $error("Alarm in standby did not request exit.");

    cal_edge_a: assert property (
        cal_enable_in && $past(cal_enable_in) && $changed(cal_out) |-> $past(src_en))
        else $error("Calibration output toggled without a source edge.");

    tick_cover_c: cover property (tick_irq_out ##[1:40] tick_irq_out);
    alarm_cover_c: cover property (alarm_irq_out ##1 alarm_flag_out ##[1:20] !alarm_flag_out);
    wake_cover_c: cover property (standby_in && hit ##1 standby_exit_out);
    cal_cover_c: cover property (cal_out ##[1:200] !cal_out);

endmodule

/* File: core/rtcab_pkg.sv */
// Constants and types shared by the clock, alarm and backup store logic.
package rtcab_pkg;

    localparam int CNT_W = 32;
    localparam int PRESC_W = 20;
    localparam logic [19:0] PRESC_RELOAD_RST = 20'h07fff;
    localparam logic [19:0] PRESC_ZERO = 20'h00000;
    localparam logic [19:0] PRESC_STEP = 20'h00001;
    localparam logic [31:0] CNT_RST = 32'h00000000;
    localparam logic [31:0] CNT_STEP = 32'h00000001;
    localparam logic [31:0] CMP_RST = 32'hffffffff;

    localparam int FAST_DIV_W = 7;
    localparam logic [6:0] FAST_DIV_LAST = 7'h7f;
    localparam logic [6:0] FAST_DIV_RST = 7'h00;
    localparam logic [6:0] FAST_DIV_STEP = 7'h01;

    localparam int CAL_W = 5;
    localparam logic [4:0] CAL_HALF_LAST = 5'h1f;
    localparam logic [4:0] CAL_RST = 5'h00;
    localparam logic [4:0] CAL_STEP = 5'h01;

    localparam int BKP_N = 10;
    localparam int BKP_W = 16;
    localparam int BKP_IDX_W = 4;
    localparam logic [15:0] BKP_RST = 16'h0000;

    typedef enum logic [1:0] {
        RTCAB_SRC_NONE = 2'h0,
        RTCAB_SRC_SLOW_XTAL = 2'h1,
        RTCAB_SRC_LP_RC = 2'h2,
        RTCAB_SRC_FAST_DIV = 2'h3
    } rtcab_src_t;

endpackage

/* File: tb/rtc_alarm_backup_unit_tb.sv */
// Self-checking testbench for the real-time clock core.
`timescale 1ns/10ps
module rtc_alarm_backup_unit_tb;
    import rtcab_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] src_sel_in = 2'h0;
    logic slow_in = 1'b0, lp_in = 1'b0, fast_in = 1'b0, rl_we = 1'b0;
    logic [19:0] rl_val = 20'h00000;
    logic cnt_load_in = 1'b0, cmp_we_in = 1'b0, clr_in = 1'b0, cal_en = 1'b0;
    logic [31:0] cnt_value_in = 32'h0, cmp_value_in = 32'h0;
    logic bkp_we_in = 1'b0, standby_in = 1'b0, ext_in = 1'b0, wdg_in = 1'b0, wakeup_in = 1'b0;
    logic [3:0] bkp_idx_in = 4'h0;
    logic [15:0] bkp_wdata_in = 16'h0000, bkp_rd;
    logic [31:0] count;
    logic tick, airq, aflag, aevt, sexit, cal;
    int fails = 0;
    int cmp_count = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    rtcab_core dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .src_sel_in(src_sel_in),
        .slow_xtal_tick_in(slow_in), .lp_rc_tick_in(lp_in), .fast_external_osc_tick_in(fast_in),
        .presc_reload_in(rl_val), .presc_reload_we_in(rl_we), .cnt_load_in(cnt_load_in),
        .cnt_value_in(cnt_value_in), .cmp_we_in(cmp_we_in), .cmp_value_in(cmp_value_in),
        .alarm_clear_in(clr_in), .cal_enable_in(cal_en), .bkp_we_in(bkp_we_in),
        .bkp_idx_in(bkp_idx_in), .bkp_wdata_in(bkp_wdata_in), .standby_in(standby_in),
        .external_reset_pin_in(ext_in), .independent_watchdog_rst_in(wdg_in),
        .wakeup_pin_in(wakeup_in), .count_out(count), .tick_irq_out(tick), .alarm_irq_out(airq),
        .alarm_flag_out(aflag), .alarm_event_out(aevt), .standby_exit_out(sexit),
        .cal_out(cal), .bkp_rdata_out(bkp_rd));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Inputs change 1 ns after the rising edge, when the edge's updates have landed.
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic tick_gap(output int gap);
        logic [31:0] c0;
        gap = 0;
        while (tick !== 1'b1 && gap < 40000) begin step(1); gap++; end
        c0 = count;
        gap = 0;
        do begin step(1); gap++; end while (tick !== 1'b1 && gap < 40000);
        check(tick, 1'b1);
        check(count, c0 + 32'h1);
    endtask

    // Looks for an alarm (sel 0) or standby exit (sel 1) pulse within n cycles.
    task automatic watch(input int sel, input int n, input logic exp);
        logic hit;
        hit = 1'b0;
        repeat (n) begin
            if (sel == 0 && airq === 1'b1) begin
                hit = 1'b1;
                check(aevt, 1'b1);
                check(aflag, 1'b1);
                check(count, cmp_value_in);
            end
            if (sel == 1 && sexit === 1'b1) hit = 1'b1;
            step(1);
        end
        check(hit, exp);
    endtask

    task automatic t_presc();
        int g;
        src_sel_in = 2'h1;
        slow_in = 1'b1;
        g = 0;
        while (tick !== 1'b1 && g < 40000) begin step(1); g++; end
        check(count, 32'h1);
        // The new reload lands at the next wrap, so this period is still the reset one.
        rl_val = 20'h00003;
        rl_we = 1'b1;
        step(1);
        rl_we = 1'b0;
        g = 1;
        while (tick !== 1'b1 && g < 40000) begin step(1); g++; end
        check(g, 32'h8000);
        tick_gap(g);
        tick_gap(g);
        tick_gap(g);
        check(g, 32'h4);
    endtask

    task automatic t_src();
        int g;
        logic [31:0] c;
        for (int s = 1; s < 4; s++) begin
            src_sel_in = 2'(s);
            slow_in = (s == 1);
            lp_in = (s == 2);
            fast_in = (s == 3);
            tick_gap(g);
            tick_gap(g);
            check(g, (s == 3) ? 32'h200 : 32'h4);
        end
        src_sel_in = 2'h0;
        step(2);
        c = count;
        step(600);
        check(count, c);
    endtask

    task automatic t_alarm();
        cnt_value_in = 32'h55;
        cnt_load_in = 1'b1;
        step(1);
        cnt_load_in = 1'b0;
        cmp_value_in = 32'h55;
        cmp_we_in = 1'b1;
        step(1);
        cmp_we_in = 1'b0;
        watch(0, 4, 1'b0);
        cmp_value_in = 32'h1234;
        cmp_we_in = 1'b1;
        step(1);
        cmp_we_in = 1'b0;
        cnt_value_in = 32'h1234;
        cnt_load_in = 1'b1;
        step(1);
        cnt_load_in = 1'b0;
        watch(0, 3, 1'b1);
        watch(0, 5, 1'b0);
        check(aflag, 1'b1);
        clr_in = 1'b1;
        step(1);
        clr_in = 1'b0;
        step(1);
        check(aflag, 1'b0);
        cnt_value_in = 32'h1233;
        cnt_load_in = 1'b1;
        step(1);
        cnt_load_in = 1'b0;
        src_sel_in = 2'h1;
        slow_in = 1'b1;
        watch(0, 12, 1'b1);
        src_sel_in = 2'h0;
        standby_in = 1'b1;
        cnt_load_in = 1'b1;
        step(1);
        cnt_load_in = 1'b0;
        watch(1, 3, 1'b0);
        cnt_value_in = 32'h1234;
        cnt_load_in = 1'b1;
        clr_in = 1'b1;
        step(1);
        cnt_load_in = 1'b0;
        clr_in = 1'b0;
        check(aflag, 1'b1);
        watch(1, 3, 1'b1);
    endtask

    task automatic t_standby();
        logic [31:0] c;
        wakeup_in = 1'b1;
        watch(1, 3, 1'b1);
        ext_in = 1'b1;
        watch(1, 3, 1'b1);
        ext_in = 1'b0;
        step(2);
        check(sexit, 1'b0);
        wdg_in = 1'b1;
        watch(1, 3, 1'b1);
        wdg_in = 1'b0;
        src_sel_in = 2'h1;
        step(3);
        c = count;
        step(20);
        check(count - c, 32'h5);
        bkp_idx_in = 4'h3;
        step(2);
        check(bkp_rd, 16'h1003);
        standby_in = 1'b0;
        wakeup_in = 1'b0;
        step(1);
        ext_in = 1'b1;
        watch(1, 4, 1'b0);
        ext_in = 1'b0;
    endtask

    task automatic t_bkp();
        for (int i = 0; i < 11; i++) begin
            bkp_idx_in = 4'(i);
            bkp_wdata_in = 16'h1000 + 16'(i);
            bkp_we_in = 1'b1;
            step(1);
        end
        bkp_we_in = 1'b0;
        for (int i = 0; i < 11; i++) begin
            bkp_idx_in = 4'(i);
            step(2);
            check(bkp_rd, (i < 10) ? 16'h1000 + 16'(i) : 16'h0000);
        end
        bkp_idx_in = 4'h4;
        bkp_wdata_in = 16'h0abc;
        bkp_we_in = 1'b1;
        step(1);
        bkp_we_in = 1'b0;
        step(2);
        check(bkp_rd, 16'h0abc);
    endtask

    task automatic t_cal();
        int n;
        src_sel_in = 2'h1;
        slow_in = 1'b1;
        cal_en = 1'b1;
        n = 0;
        while (cal !== 1'b1 && n < 200) begin step(1); n++; end
        while (cal !== 1'b0 && n < 200) begin step(1); n++; end
        n = 0;
        while (cal !== 1'b1 && n < 200) begin step(1); n++; end
        check(n, 32'h20);
        cal_en = 1'b0;
        step(2);
        check(cal, 1'b0);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole run needs about 68000 cycles, most of it the two one-second reset periods in t_presc.
    initial begin
        #1800000;
        fails++;
        summarize();
    end

    initial begin
        step(5);
        rst_in = 1'b0;
        check(count, 32'h0);
        check(aflag, 1'b0);
        check(cal, 1'b0);
        t_presc();
        t_src();
        t_bkp();
        t_alarm();
        t_standby();
        t_cal();
        summarize();
    end
endmodule
